// ### hdl/lfe_pkg.sv
// Constants, register map and types for link and flow-control error reporting
package lfe_pkg;

	// ***************************************
	// Register byte offsets
	// ***************************************
	localparam logic [7:0] ADDR_UNC_STATUS = 8'h00;
	localparam logic [7:0] ADDR_UNC_MASK   = 8'h04;
	localparam logic [7:0] ADDR_UNC_SEV    = 8'h08;
	localparam logic [7:0] ADDR_COR_STATUS = 8'h0c;
	localparam logic [7:0] ADDR_COR_MASK   = 8'h10;
	localparam logic [7:0] ADDR_DEV_CTLSTS = 8'h14;
	localparam logic [7:0] ADDR_PRI_CMDSTS = 8'h18;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] ADDR_IRQ_MASK   = 8'h20;

	// ***************************************
	// Field positions
	// ***************************************
	localparam int UNC_W      = 3;
	localparam int UNC_OVF    = 0;
	localparam int UNC_FLOW   = 1;
	localparam int UNC_LINK   = 2;
	localparam int COR_W      = 4;
	localparam int COR_BTLP   = 0;
	localparam int COR_BDLLP  = 1;
	localparam int COR_RNRO   = 2;
	localparam int COR_RTTO   = 3;
	localparam int DEV_COR_EN = 0;
	localparam int DEV_NFT_EN = 1;
	localparam int DEV_FTL_EN = 2;
	localparam int DEV_COR_DT = 16;
	localparam int DEV_NFT_DT = 17;
	localparam int DEV_FTL_DT = 18;
	localparam int PRI_SERREN = 0;
	localparam int PRI_SSERR  = 16;
	localparam int IRQ_W      = UNC_W + COR_W;

	// ***************************************
	// Reset values
	// ***************************************
	localparam logic [UNC_W-1:0] RST_UNC_SEV  = 3'h7;
	localparam logic [UNC_W-1:0] RST_UNC_MASK = 3'h0;
	localparam logic [COR_W-1:0] RST_COR_MASK = 4'h0;
	localparam logic [IRQ_W-1:0] RST_IRQ_MASK = 7'h00;

	// ***************************************
	// Link-layer widths and limits
	// ***************************************
	localparam int              SEQ_W        = 12;
	localparam int              REPLAY_NUM_W = 2;
	localparam int              FC_HDR_W     = 8;
	localparam int              FC_DATA_W    = 12;
	localparam logic [7:0]      FC_HDR_MAX   = 8'h7f;
	localparam logic [11:0]     FC_DATA_MAX  = 12'h7ff;
	localparam int              FC_TYPES     = 3;

	// Error message kinds
	typedef enum logic [1:0] {MSG_COR, MSG_NONFATAL, MSG_FATAL} lfe_msg_t;

endpackage

// ### hdl/lfe_fc_check.sv
// Flow-control credit advertisement checker
`timescale 1ns/1ps
module lfe_fc_check
	import lfe_pkg::*;
#(
	parameter int                HDR_W    = FC_HDR_W,
	parameter int                DATA_W   = FC_DATA_W,
	parameter logic [HDR_W-1:0]  MIN_HDR  = HDR_W'(1),
	parameter logic [DATA_W-1:0] MIN_DATA = DATA_W'(1)
) (
	input  wire logic              clk,           // Core clock
	input  wire logic              rst_n,         // Async reset, active low
	input  wire logic              init_valid,    // InitFC received
	input  wire logic              update_valid,  // UpdateFC received
	input  wire logic [1:0]        type_sel,      // Credit type index
	input  wire logic [HDR_W-1:0]  hdr_credit,    // Header credit field
	input  wire logic [DATA_W-1:0] data_credit,   // Data credit field
	input  wire logic [HDR_W-1:0]  hdr_consumed,  // Header credits consumed
	input  wire logic [DATA_W-1:0] data_consumed, // Data credits consumed
	output logic                   err_r          // Protocol error pulse
);

	logic [FC_TYPES-1:0] inf_hdr_r;
	logic [FC_TYPES-1:0] inf_data_r;
	logic [HDR_W-1:0]    hdr_out;
	logic [DATA_W-1:0]   data_out;
	logic                min_err;
	logic                lim_err;
	logic                inf_err;

	assign hdr_out  = hdr_credit - hdr_consumed;
	assign data_out = data_credit - data_consumed;
	// Zero in InitFC means infinite credit
	assign min_err  = init_valid && (((hdr_credit != '0) && (hdr_credit < MIN_HDR)) ||
		((data_credit != '0) && (data_credit < MIN_DATA)));
	assign inf_err  = update_valid && ((inf_hdr_r[type_sel] && (hdr_credit != '0)) ||
		(inf_data_r[type_sel] && (data_credit != '0)));
	assign lim_err  = update_valid && ((!inf_hdr_r[type_sel] && (hdr_out > FC_HDR_MAX)) ||
		(!inf_data_r[type_sel] && (data_out > FC_DATA_MAX)));

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			inf_hdr_r  <= '0;
			inf_data_r <= '0;
		end else if (init_valid) begin
			inf_hdr_r[type_sel]  <= (hdr_credit == '0);
			inf_data_r[type_sel] <= (data_credit == '0);
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			err_r <= 1'b0;
		end else begin
			err_r <= min_err || inf_err || lim_err;
		end
	end

	a_fc_minimum: assert property (@(posedge clk) disable iff (!rst_n)
		init_valid && (hdr_credit != '0) && (hdr_credit < MIN_HDR) |=> err_r)
		else $error("Low initial header credit not flagged");
	a_fc_limit: assert property (@(posedge clk) disable iff (!rst_n)
		update_valid && !inf_data_r[type_sel] && (data_out > FC_DATA_MAX) |=> err_r)
		else $error("Data credits above limit not flagged");
	a_fc_infinite: assert property (@(posedge clk) disable iff (!rst_n)
		update_valid && inf_hdr_r[type_sel] && (hdr_credit != '0) |=> err_r)
		else $error("Non-zero update after infinite credit not flagged");

endmodule // lfe_fc_check

// ### hdl/lfe_top.sv
// Link and flow-control error detection and reporting with AHB-Lite registers
`timescale 1ns/1ps
module lfe_top
	import lfe_pkg::*;
#(
	parameter logic [FC_HDR_W-1:0]  MIN_HDR  = FC_HDR_W'(1),
	parameter logic [FC_DATA_W-1:0] MIN_DATA = FC_DATA_W'(1)
) (
	input  wire logic                 CLK,            // Core clock, 40 MHz
	input  wire logic                 RST_N,          // Async reset, active low
	input  wire logic                 HSEL,           // AHB slave select
	input  wire logic [31:0]          HADDR,          // AHB address
	input  wire logic [1:0]           HTRANS,         // AHB transfer type
	input  wire logic                 HWRITE,         // AHB write
	input  wire logic [2:0]           HSIZE,          // AHB size
	input  wire logic [31:0]          HWDATA,         // AHB write data
	input  wire logic                 HREADY,         // AHB bus ready
	output logic      [31:0]          HRDATA,         // AHB read data
	output logic                      HREADYOUT,      // AHB slave ready
	output logic                      HRESP,          // AHB response, always OKAY
	input  wire logic                 RX_HDR_OVF,     // Header buffer overflow pulse
	input  wire logic                 RX_DATA_OVF,    // Data buffer overflow pulse
	input  wire logic                 FC_INIT_VALID,  // InitFC received pulse
	input  wire logic                 FC_UPD_VALID,   // UpdateFC received pulse
	input  wire logic [1:0]           FC_TYPE,        // Credit type index 0..2
	input  wire logic [FC_HDR_W-1:0]  FC_HDR_CREDIT,  // Header credit value
	input  wire logic [FC_DATA_W-1:0] FC_DATA_CREDIT, // Data credit value
	input  wire logic [FC_HDR_W-1:0]  FC_HDR_USED,    // Header credits consumed
	input  wire logic [FC_DATA_W-1:0] FC_DATA_USED,   // Data credits consumed
	input  wire logic                 ACKNAK_VALID,   // Ack or Nak received pulse
	input  wire logic [SEQ_W-1:0]     ACKNAK_SEQ,     // Received sequence number
	input  wire logic [SEQ_W-1:0]     ACKD_SEQ,       // Last acknowledged sequence
	input  wire logic [SEQ_W-1:0]     NEXT_TX_SEQ,    // Next transmit sequence
	input  wire logic                 TLP_END_VALID,  // Packet end seen pulse
	input  wire logic                 TLP_END_EDB,    // Ended with EDB, else END
	input  wire logic                 TLP_LCRC_OK,    // LCRC matches
	input  wire logic                 TLP_LCRC_INV,   // LCRC is the inverted value
	input  wire logic                 TLP_LINK_BAD,   // Otherwise invalid at link layer
	input  wire logic                 DLLP_VALID,     // Link packet received pulse
	input  wire logic                 DLLP_CRC_OK,    // Link packet CRC matches
	input  wire logic                 REPLAY_START,   // Replay initiated pulse
	input  wire logic                 ACK_PROGRESS,   // Forward progress ack pulse
	input  wire logic                 REPLAY_TMR_EXP, // Replay timer expired pulse
	output logic                      MSG_VALID,      // Error message request pulse
	output logic      [1:0]           MSG_KIND,       // Message kind
	output logic                      IRQ             // Interrupt, active high level
);

	// ***************************************
	// Bus slave
	// ***************************************
	logic                    wr_pend_r;
	logic                    rd_pend_r;
	logic [7:0]              addr_r;
	logic                    wr_en;
	logic [31:0]             rd_mux;

	logic [UNC_W-1:0]        unc_status_r;
	logic [UNC_W-1:0]        unc_mask_r;
	logic [UNC_W-1:0]        unc_sev_r;
	logic [COR_W-1:0]        cor_status_r;
	logic [COR_W-1:0]        cor_mask_r;
	logic [2:0]              dev_en_r;
	logic [2:0]              dev_det_r;
	logic                    syserr_en_r;
	logic                    sserr_r;
	logic [IRQ_W-1:0]        irq_status_r;
	logic [IRQ_W-1:0]        irq_mask_r;
	logic [REPLAY_NUM_W-1:0] replay_num_r;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		hit = (a == off);
	endfunction

	assign wr_en = wr_pend_r;
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			addr_r    <= 8'h00;
			HREADYOUT <= 1'b1;
		end else begin
			wr_pend_r <= 1'b0;
			rd_pend_r <= 1'b0;
			HREADYOUT <= 1'b1;
			if (HSEL && HREADY && HTRANS[1] && (HSIZE == 3'h2)) begin
				addr_r    <= {HADDR[7:2], 2'b00};
				wr_pend_r <= HWRITE;
				rd_pend_r <= !HWRITE;
				// One wait state on reads gives time for the registered HRDATA
				HREADYOUT <= HWRITE;
			end
		end
	end

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(addr_r, ADDR_UNC_STATUS)) begin
			rd_mux[UNC_W-1:0] = unc_status_r;
		end else if (hit(addr_r, ADDR_UNC_MASK)) begin
			rd_mux[UNC_W-1:0] = unc_mask_r;
		end else if (hit(addr_r, ADDR_UNC_SEV)) begin
			rd_mux[UNC_W-1:0] = unc_sev_r;
		end else if (hit(addr_r, ADDR_COR_STATUS)) begin
			rd_mux[COR_W-1:0] = cor_status_r;
		end else if (hit(addr_r, ADDR_COR_MASK)) begin
			rd_mux[COR_W-1:0] = cor_mask_r;
		end else if (hit(addr_r, ADDR_DEV_CTLSTS)) begin
			rd_mux[DEV_FTL_EN:DEV_COR_EN] = dev_en_r;
			rd_mux[DEV_FTL_DT:DEV_COR_DT] = dev_det_r;
		end else if (hit(addr_r, ADDR_PRI_CMDSTS)) begin
			rd_mux[PRI_SERREN] = syserr_en_r;
			rd_mux[PRI_SSERR]  = sserr_r;
		end else if (hit(addr_r, ADDR_IRQ_STATUS)) begin
			rd_mux[IRQ_W-1:0] = irq_status_r;
		end else if (hit(addr_r, ADDR_IRQ_MASK)) begin
			rd_mux[IRQ_W-1:0] = irq_mask_r;
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= 32'h0000_0000;
			HRESP  <= 1'b0;
		end else begin
			HRESP <= 1'b0;
			if (rd_pend_r) begin
				HRDATA <= rd_mux;
			end
		end
	end

	// ***************************************
	// Error event detection
	// ***************************************
	logic             fc_err;
	logic             seq_err;
	logic             bad_tlp;
	logic             bad_dllp;
	logic             rollover;
	logic [SEQ_W-1:0] seq_dist;
	logic [SEQ_W-1:0] seq_window;
	logic [UNC_W-1:0] unc_ev;
	logic [COR_W-1:0] cor_ev;

	lfe_fc_check #(
		.HDR_W    (FC_HDR_W),
		.DATA_W   (FC_DATA_W),
		.MIN_HDR  (MIN_HDR),
		.MIN_DATA (MIN_DATA)
	) u_fc_check (
		.clk           (CLK),
		.rst_n         (RST_N),
		.init_valid    (FC_INIT_VALID),
		.update_valid  (FC_UPD_VALID),
		.type_sel      (FC_TYPE),
		.hdr_credit    (FC_HDR_CREDIT),
		.data_credit   (FC_DATA_CREDIT),
		.hdr_consumed  (FC_HDR_USED),
		.data_consumed (FC_DATA_USED),
		.err_r         (fc_err)
	);

	// Outstanding window is ACKD_SEQ+1 .. NEXT_TX_SEQ-1; ACKD_SEQ itself is a duplicate
	assign seq_dist   = NEXT_TX_SEQ - 12'h001 - ACKNAK_SEQ;
	assign seq_window = NEXT_TX_SEQ - 12'h001 - ACKD_SEQ;
	assign seq_err    = ACKNAK_VALID && (seq_dist > seq_window);
	assign bad_tlp    = TLP_END_VALID && (TLP_END_EDB ? !TLP_LCRC_INV :
		(!TLP_LCRC_OK || TLP_LINK_BAD));
	assign bad_dllp   = DLLP_VALID && !DLLP_CRC_OK;
	assign rollover   = REPLAY_START && !ACK_PROGRESS && (replay_num_r == '1);

	always_comb begin
		unc_ev           = '0;
		unc_ev[UNC_OVF]  = RX_HDR_OVF || RX_DATA_OVF;
		unc_ev[UNC_FLOW] = fc_err;
		unc_ev[UNC_LINK] = seq_err;
		cor_ev           = '0;
		cor_ev[COR_BTLP] = bad_tlp;
		cor_ev[COR_BDLLP]= bad_dllp;
		cor_ev[COR_RNRO] = rollover;
		cor_ev[COR_RTTO] = REPLAY_TMR_EXP;
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			replay_num_r <= '0;
		end else if (ACK_PROGRESS) begin
			replay_num_r <= '0;
		end else if (REPLAY_START) begin
			replay_num_r <= replay_num_r + 1'b1;
		end
	end

	// ***************************************
	// Status and control registers
	// ***************************************
	function automatic logic [31:0] w1c(input logic [7:0] a, input logic [7:0] off,
		input logic en, input logic [31:0] d);
		w1c = (en && (a == off)) ? d : 32'h0000_0000;
	endfunction

	logic [31:0] unc_clr;
	logic [31:0] cor_clr;
	logic [31:0] dev_clr;
	logic [31:0] pri_clr;
	logic [31:0] irq_clr;
	logic [2:0]  det_set;
	logic        send_unc;
	logic        send_fatal;
	logic        send_cor;

	assign unc_clr = w1c(addr_r, ADDR_UNC_STATUS, wr_en, HWDATA);
	assign cor_clr = w1c(addr_r, ADDR_COR_STATUS, wr_en, HWDATA);
	assign dev_clr = w1c(addr_r, ADDR_DEV_CTLSTS, wr_en, HWDATA);
	assign pri_clr = w1c(addr_r, ADDR_PRI_CMDSTS, wr_en, HWDATA);
	assign irq_clr = w1c(addr_r, ADDR_IRQ_STATUS, wr_en, HWDATA);

	assign det_set[0] = |cor_ev;
	assign det_set[1] = |(unc_ev & ~unc_sev_r);
	assign det_set[2] = |(unc_ev & unc_sev_r);
	// Set wins over a same-cycle clear
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			unc_status_r <= '0;
			cor_status_r <= '0;
			dev_det_r    <= '0;
			irq_status_r <= '0;
		end else begin
			unc_status_r <= (unc_status_r & ~unc_clr[UNC_W-1:0]) | unc_ev;
			cor_status_r <= (cor_status_r & ~cor_clr[COR_W-1:0]) | cor_ev;
			dev_det_r    <= (dev_det_r & ~dev_clr[DEV_FTL_DT:DEV_COR_DT]) | det_set;
			irq_status_r <= (irq_status_r & ~irq_clr[IRQ_W-1:0]) | {cor_ev, unc_ev};
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			unc_mask_r <= RST_UNC_MASK;
			unc_sev_r  <= RST_UNC_SEV;
			cor_mask_r <= RST_COR_MASK;
			dev_en_r   <= '0;
			syserr_en_r <= 1'b0;
			irq_mask_r <= RST_IRQ_MASK;
		end else if (wr_en) begin
			if (hit(addr_r, ADDR_UNC_MASK)) begin
				unc_mask_r <= HWDATA[UNC_W-1:0];
			end else if (hit(addr_r, ADDR_UNC_SEV)) begin
				unc_sev_r <= HWDATA[UNC_W-1:0];
			end else if (hit(addr_r, ADDR_COR_MASK)) begin
				cor_mask_r <= HWDATA[COR_W-1:0];
			end else if (hit(addr_r, ADDR_DEV_CTLSTS)) begin
				dev_en_r <= HWDATA[DEV_FTL_EN:DEV_COR_EN];
			end else if (hit(addr_r, ADDR_PRI_CMDSTS)) begin
				syserr_en_r <= HWDATA[PRI_SERREN];
			end else if (hit(addr_r, ADDR_IRQ_MASK)) begin
				irq_mask_r <= HWDATA[IRQ_W-1:0];
			end
		end
	end

	// ***************************************
	// Error messages and system error
	// ***************************************
	assign send_fatal = |(unc_ev & ~unc_mask_r & unc_sev_r) && dev_en_r[2];
	assign send_unc   = send_fatal ||
		(|(unc_ev & ~unc_mask_r & ~unc_sev_r) && dev_en_r[1]);
	assign send_cor   = |(cor_ev & ~cor_mask_r) && dev_en_r[0];

	// Most severe message wins when several errors coincide
	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			MSG_VALID <= 1'b0;
			MSG_KIND  <= 2'h0;
		end else begin
			MSG_VALID <= send_unc || send_cor;
			if (send_fatal) begin
				MSG_KIND <= MSG_FATAL;
			end else if (send_unc) begin
				MSG_KIND <= MSG_NONFATAL;
			end else if (send_cor) begin
				MSG_KIND <= MSG_COR;
			end
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			sserr_r <= 1'b0;
		end else begin
			sserr_r <= (sserr_r & ~pri_clr[PRI_SSERR]) | (send_unc && syserr_en_r);
		end
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= |((((irq_status_r & ~irq_clr[IRQ_W-1:0]) | {cor_ev, unc_ev})) & irq_mask_r);
		end
	end

	// ***************************************
	// Assertions
	// ***************************************
	a_overflow_flag: assert property (@(posedge CLK) disable iff (!RST_N)
		RX_HDR_OVF || RX_DATA_OVF |=> unc_status_r[UNC_OVF])
		else $error("Overflow did not set flag");
	a_severity_detect: assert property (@(posedge CLK) disable iff (!RST_N)
		(unc_ev[UNC_LINK] && !unc_sev_r[UNC_LINK]) |=> dev_det_r[1])
		else $error("Nonfatal detected not set");
	a_fatal_message: assert property (@(posedge CLK) disable iff (!RST_N)
		(unc_ev[UNC_OVF] && unc_sev_r[UNC_OVF] && !unc_mask_r[UNC_OVF] && dev_en_r[2])
		|=> MSG_VALID && (MSG_KIND == MSG_FATAL))
		else $error("Fatal message missing");
	a_serr_cause: assert property (@(posedge CLK) disable iff (!RST_N)
		$rose(sserr_r) |-> $past(syserr_en_r) && $past(send_unc))
		else $error("System error set without cause");
	a_masked_quiet: assert property (@(posedge CLK) disable iff (!RST_N)
		(cor_ev != '0) && ((cor_ev & ~cor_mask_r) == '0) && (unc_ev == '0) |=> !MSG_VALID)
		else $error("Masked error sent a message");
	a_seq_flag: assert property (@(posedge CLK) disable iff (!RST_N)
		seq_err |=> unc_status_r[UNC_LINK] ##1 unc_status_r[UNC_LINK] || $past(unc_clr[UNC_LINK]))
		else $error("Bad sequence number not flagged");
	a_edb_bad: assert property (@(posedge CLK) disable iff (!RST_N)
		TLP_END_VALID && TLP_END_EDB && !TLP_LCRC_INV |=> cor_status_r[COR_BTLP])
		else $error("EDB packet not flagged");
	a_end_bad: assert property (@(posedge CLK) disable iff (!RST_N)
		TLP_END_VALID && !TLP_END_EDB && (!TLP_LCRC_OK || TLP_LINK_BAD)
		|=> cor_status_r[COR_BTLP])
		else $error("END packet not flagged");
	a_cor_detect: assert property (@(posedge CLK) disable iff (!RST_N)
		bad_dllp |=> cor_status_r[COR_BDLLP] && dev_det_r[0])
		else $error("Bad link packet not reported");
	a_rollover_flag: assert property (@(posedge CLK) disable iff (!RST_N)
		REPLAY_START && !ACK_PROGRESS && (replay_num_r == '1)
		|=> cor_status_r[COR_RNRO] && (replay_num_r == '0))
		else $error("Replay rollover not flagged");
	a_timeout_flag: assert property (@(posedge CLK) disable iff (!RST_N)
		REPLAY_TMR_EXP |=> cor_status_r[COR_RTTO])
		else $error("Replay timeout not flagged");
	a_sticky_hold: assert property (@(posedge CLK) disable iff (!RST_N)
		cor_status_r[COR_RTTO] && !cor_clr[COR_RTTO] |=> cor_status_r[COR_RTTO])
		else $error("Status flag dropped without clear");
	c_fatal_msg: cover property (@(posedge CLK) disable iff (!RST_N)
		MSG_VALID && (MSG_KIND == MSG_FATAL));
	c_cor_msg: cover property (@(posedge CLK) disable iff (!RST_N)
		MSG_VALID && (MSG_KIND == MSG_COR));
	c_serr: cover property (@(posedge CLK) disable iff (!RST_N) $rose(sserr_r));
	c_irq: cover property (@(posedge CLK) disable iff (!RST_N) $rose(IRQ));
endmodule // lfe_top

// ### sim/lfe_link_model.sv
// Link partner model issuing receive-side events to the block
`timescale 1ns/1ps
module lfe_link_model (
	input  wire logic        clk, // Core clock
	output logic      [14:0] ev   // Event pulses with their qualifiers
);
	initial ev = 15'h0000;
	// One-cycle event; qualifiers drop with the pulse
	task automatic send(input logic [14:0] p);
		@(posedge clk);
		ev <= p;
		@(posedge clk);
		ev <= 15'h0000;
	endtask
endmodule // lfe_link_model

// ### sim/tb_lfe_top.sv
// Self-checking testbench for link and flow-control error reporting
`timescale 1ns/1ps
module tb_lfe_top;
	import lfe_pkg::*;
	localparam logic [7:0] US = ADDR_UNC_STATUS, DV = ADDR_DEV_CTLSTS;
	localparam logic [7:0] PR = ADDR_PRI_CMDSTS, CS = ADDR_COR_STATUS;
	logic        CLK, RST_N, HSEL, HWRITE, HREADYOUT, HRESP, MSG_VALID, IRQ;
	logic [31:0] HADDR, HWDATA, HRDATA;
	logic [1:0]  HTRANS, MSG_KIND, FC_TYPE;
	logic [2:0]  HSIZE;
	logic [7:0]  hc, hu;
	logic [11:0] dc, du, sq, ak, nx;
	logic [14:0] ev;
	logic [14:0] cp [8] = '{15'h0060, 15'h0160, 15'h0020, 15'h00a0, 15'h02a0, 15'h0400,
		15'h0c00, 15'h4000};
	logic [3:0]  ce [8] = '{4'h1, 4'h0, 4'h1, 4'h0, 4'h1, 4'h2, 4'h0, 4'h8};
	int          n_fail = 0, total_checks = 0, n_msg = 0;

	lfe_link_model lfe_link_model_inst (.clk(CLK), .ev(ev));
	lfe_top #(.MIN_HDR(8'h02), .MIN_DATA(12'h002)) lfe_top_inst (
		.CLK(CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
		.HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADYOUT),
		.HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_HDR_OVF(ev[0]),
		.RX_DATA_OVF(ev[1]), .FC_INIT_VALID(ev[2]), .FC_UPD_VALID(ev[3]), .FC_TYPE(FC_TYPE),
		.FC_HDR_CREDIT(hc), .FC_DATA_CREDIT(dc), .FC_HDR_USED(hu), .FC_DATA_USED(du),
		.ACKNAK_VALID(ev[4]), .ACKNAK_SEQ(sq), .ACKD_SEQ(ak), .NEXT_TX_SEQ(nx),
		.TLP_END_VALID(ev[5]), .TLP_END_EDB(ev[6]), .TLP_LCRC_OK(ev[7]),
		.TLP_LCRC_INV(ev[8]), .TLP_LINK_BAD(ev[9]), .DLLP_VALID(ev[10]),
		.DLLP_CRC_OK(ev[11]), .REPLAY_START(ev[12]), .ACK_PROGRESS(ev[13]),
		.REPLAY_TMR_EXP(ev[14]), .MSG_VALID(MSG_VALID), .MSG_KIND(MSG_KIND), .IRQ(IRQ));

	initial begin
		CLK = 1'b0;
		forever #12.5 CLK = ~CLK;
	end
	always @(posedge CLK) if (MSG_VALID === 1'b1) n_msg++;

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", n, e, g);
		end
	endtask
	// Single AHB-Lite word transfer, waits on ready
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		@(posedge CLK);
		HSEL <= 1'b1;
		HADDR <= {24'h000000, a};
		HTRANS <= 2'h2;
		HWRITE <= w;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		HTRANS <= 2'h0;
		HSEL <= 1'b0;
		HWDATA <= d;
		do @(posedge CLK); while (HREADYOUT !== 1'b1);
		q = HRDATA;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk($sformatf("reg %h", a), e, q);
		chk("hresp", 32'h0, {31'h0, HRESP});
	endtask
	task automatic hit(input logic [14:0] p, input logic [7:0] a, input logic [31:0] e);
		lfe_link_model_inst.send(p);
		repeat (3) @(posedge CLK);
		rd(a, e);
	endtask
	task automatic msg(input int n, input logic [1:0] k);
		chk("message count", n, n_msg);
		chk("message kind", {30'h0, k}, {30'h0, MSG_KIND});
	endtask
	task automatic fcu(input logic [7:0] h, input logic [11:0] d, input logic [31:0] e);
		hc <= h;
		dc <= d;
		hit(15'h0008, US, e);
		wr(US, e);
	endtask
	task automatic results();
		$display("checks %0d, mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	initial begin
		repeat (30000) @(posedge CLK);
		n_fail++;
		results();
	end

	initial begin
		{RST_N, HSEL, HWRITE, HADDR, HWDATA, HTRANS, FC_TYPE, hc, hu, dc, du} = '0;
		{sq, ak, nx} = '0;
		HSIZE = 3'h2;
		repeat (4) @(posedge CLK);
		RST_N <= 1'b1;
		rd(ADDR_UNC_SEV, 32'h7);
		rd(8'h3c, 32'h0);
		wr(DV, 32'h7);
		wr(PR, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h7f);
		hit(15'h0001, US, 32'h1);
		rd(DV, 32'h40007);
		msg(1, 2'h2);
		rd(PR, 32'h10001);
		chk("irq", 1, IRQ);
		hit(15'h0002, US, 32'h1);
		wr(US, 32'h1);
		wr(DV, 32'h70007);
		wr(PR, 32'h10000);
		wr(ADDR_IRQ_STATUS, 32'h7f);
		repeat (2) @(posedge CLK);
		chk("irq", 0, IRQ);
		rd(US, 32'h0);
		// Sequence window: equal to acked passes, next-to-send fails
		wr(ADDR_UNC_SEV, 32'h0);
		ak <= 12'h005;
		nx <= 12'h00a;
		sq <= 12'h005;
		hit(15'h0010, US, 32'h0);
		sq <= 12'h00a;
		hit(15'h0010, US, 32'h4);
		rd(DV, 32'h20007);
		msg(3, 2'h1);
		rd(PR, 32'h0);
		// Masked error: detected but no message
		wr(US, 32'h7);
		wr(DV, 32'h70007);
		wr(ADDR_UNC_MASK, 32'h7);
		wr(ADDR_UNC_SEV, 32'h7);
		wr(PR, 32'h1);
		wr(ADDR_IRQ_MASK, 32'h78);
		hc <= 8'h01;
		dc <= 12'h010;
		hit(15'h0004, US, 32'h2);
		msg(3, 2'h1);
		rd(PR, 32'h1);
		rd(DV, 32'h40007);
		chk("irq", 0, IRQ);
		wr(US, 32'h2);
		wr(ADDR_UNC_MASK, 32'h0);
		FC_TYPE <= 2'h1;
		hc <= 8'h00;
		dc <= 12'h000;
		hit(15'h0004, US, 32'h0);
		hc <= 8'h03;
		hit(15'h0008, US, 32'h2);
		msg(4, 2'h2);
		wr(US, 32'h2);
		FC_TYPE <= 2'h2;
		hc <= 8'h0a;
		dc <= 12'h064;
		hit(15'h0004, US, 32'h0);
		fcu(8'h7f, 12'h7ff, 32'h0);
		fcu(8'h80, 12'h000, 32'h2);
		fcu(8'h00, 12'h800, 32'h2);
		wr(DV, 32'h70007);
		for (int i = 0; i < 8; i++) begin
			hit(cp[i], CS, {28'h0, ce[i]});
			wr(CS, 32'hf);
		end
		rd(DV, 32'h10007);
		msg(11, 2'h0);
		chk("irq", 1, IRQ);
		repeat (3) lfe_link_model_inst.send(15'h1000);
		lfe_link_model_inst.send(15'h2000);
		repeat (3) lfe_link_model_inst.send(15'h1000);
		hit(15'h0000, CS, 32'h0);
		hit(15'h1000, CS, 32'h4);
		wr(ADDR_COR_MASK, 32'hf);
		hit(15'h0400, CS, 32'h6);
		msg(12, 2'h0);
		results();
	end
endmodule // tb_lfe_top
